//--- design/sli_pkg.sv
// Summary of operation
// - Above about 75 degrees the power stage stops and the error flag sets.
// - After a trip, work resumes once cool and a fault-reset is received.
// - Without faults the power indicator pulses green once every second.
// - Any error turns the power indicator red, flashing the error class.
// - Count 1 general, 2 voltage, 3 temp, 4 overcurrent, 5 ctrl, 6 watchdog.
// - The link indicator is lit while cabled and flickers during traffic.
// - The run indicator is off in the INIT state.
// - The run indicator blinks in the PRE-OPERATIONAL state.
// - The run indicator single-flashes in the SAFE-OPERATIONAL state.
// - The run indicator flickers before INIT and while loading firmware.
// - The run indicator is steadily lit in the OPERATIONAL state.
// - Fault indicator: off, blink bad config, double watchdog, lit on hang.
// - The fault indicator single-flashes after a local-error state change.
// - The fault indicator triple-flashes on an application error.
// - The fault indicator flickers on a booting error.
package sli_pkg;
	timeunit 1ns;
	timeprecision 1ns;
	// ****************************************
	// Timing
	// ****************************************
	localparam int unsigned CLK_HZ = 10_000_000;
	localparam int unsigned TICK_US = 50;
	localparam int unsigned TICK_CYC = CLK_HZ / 1_000_000 * TICK_US;
	// Pattern slots in 50 us ticks
	localparam int unsigned FLICKER_US = 50_000;
	localparam int unsigned FLICKER_TICKS = FLICKER_US / TICK_US;
	localparam int unsigned BLINK_US = 200_000;
	localparam int unsigned BLINK_TICKS = BLINK_US / TICK_US;
	localparam int unsigned BEAT_US = 1_000_000;
	localparam int unsigned BEAT_TICKS = BEAT_US / TICK_US;
	localparam int unsigned PULSE_US = 100_000;
	localparam int unsigned PULSE_TICKS = PULSE_US / TICK_US;
	// Slots of 200 ms: fieldbus flash frame is 5 slots after the last flash
	localparam logic [3:0] FLASH_GAP_SLOTS = 4'h5;
	// Red count frame: pause of 4 slots after the last flash
	localparam logic [4:0] COUNT_GAP_SLOTS = 5'h04;

	// ****************************************
	// Codes
	// ****************************************
	typedef enum logic [2:0] {
		SLI_ST_BOOT,
		SLI_ST_INIT,
		SLI_ST_PREOP,
		SLI_ST_SAFEOP,
		SLI_ST_OP
	} sli_slave_t;

	localparam logic [2:0] CLS_GENERAL = 3'h1;
	localparam logic [2:0] CLS_VOLTAGE = 3'h2;
	localparam logic [2:0] CLS_TEMP = 3'h3;
	localparam logic [2:0] CLS_OVERCUR = 3'h4;
	localparam logic [2:0] CLS_CTRL = 3'h5;
	localparam logic [2:0] CLS_WDOG = 3'h6;
endpackage : sli_pkg

//--- design/sli_status_led.sv
module sli_status_led #(
	parameter int unsigned TICK_CYC = sli_pkg::TICK_CYC, // Cycles per tick
	parameter int unsigned BLINK_TICKS = sli_pkg::BLINK_TICKS, // Slot length
	parameter int unsigned FLICKER_TICKS = sli_pkg::FLICKER_TICKS, // Flicker
	parameter int unsigned BEAT_TICKS = sli_pkg::BEAT_TICKS, // Heartbeat
	parameter int unsigned PULSE_TICKS = sli_pkg::PULSE_TICKS // Green pulse
) (
	input wire logic clk_sys_i, // System clock
	input wire logic reset_n_i, // Sync reset, low
	input wire logic temp_trip_i, // Board above trip temp
	input wire logic fault_reset_i, // Fault-reset command pulse
	input wire logic err_general_i, // General error
	input wire logic err_voltage_i, // Voltage error
	input wire logic err_overcur_i, // Overcurrent error
	input wire logic err_ctrl_i, // Controller error
	input wire logic err_wdog_i, // Watchdog reset error
	input wire logic link_up_i, // Cable connected
	input wire logic link_act_i, // Frame traffic
	input wire sli_pkg::sli_slave_t slave_state_i, // Slave state
	input wire logic bootloader_i, // Firmware loading
	input wire logic fb_cfg_err_i, // Invalid configuration
	input wire logic fb_local_err_i, // Local error state change
	input wire logic fb_wdog_err_i, // Watchdog timeout
	input wire logic fb_app_err_i, // Application error
	input wire logic fb_boot_err_i, // Booting error
	input wire logic fb_ctrl_fail_i, // Controller not responding
	output logic power_stage_en_o, // Power stage enable
	output logic temp_fault_o, // Overtemp error flag
	output logic power_green_o, // Power indicator green
	output logic power_red_o, // Power indicator red
	output logic link_indicator_o, // Link indicator
	output logic run_indicator_o, // Run indicator
	output logic fault_indicator_o // Fault indicator
);
	timeunit 1ns;
	timeprecision 1ns;
	// ****************************************
	// Tick and slot dividers
	// ****************************************
	logic [15:0] pre_reg;
	logic [15:0] slot_reg;
	logic [15:0] flk_reg;
	logic [15:0] beat_reg;
	logic tick;
	logic slot_end;
	logic flk_end;
	logic beat_end;
	assign tick = (pre_reg == 16'(TICK_CYC - 1));
	assign slot_end = tick && (slot_reg == 16'(BLINK_TICKS - 1));
	assign flk_end = tick && (flk_reg == 16'(FLICKER_TICKS - 1));
	assign beat_end = tick && (beat_reg == 16'(BEAT_TICKS - 1));

	always_ff @(posedge clk_sys_i)
	begin
		if (!reset_n_i)
		begin
			pre_reg <= '0;
			slot_reg <= '0;
			flk_reg <= '0;
			beat_reg <= '0;
		end
		else
		begin
			pre_reg <= tick ? '0 : pre_reg + 16'h0001;
			if (tick)
			begin
				slot_reg <= slot_end ? '0 : slot_reg + 16'h0001;
				flk_reg <= flk_end ? '0 : flk_reg + 16'h0001;
				beat_reg <= beat_end ? '0 : beat_reg + 16'h0001;
			end
		end
	end

	// ****************************************
	// Blink, flicker and flash frames
	// ****************************************
	logic blink_reg;
	logic flicker_reg;
	logic [3:0] fslot_reg;
	logic single_w;
	logic double_w;
	logic triple_w;
	logic [3:0] flash_len;
	// Frame: n flashes on even slots, then a long off gap
	assign flash_len = 4'h6 + sli_pkg::FLASH_GAP_SLOTS;
	assign single_w = (fslot_reg == 4'h0);
	assign double_w = (fslot_reg == 4'h0) || (fslot_reg == 4'h2);
	assign triple_w = double_w || (fslot_reg == 4'h4);

	always_ff @(posedge clk_sys_i)
	begin
		if (!reset_n_i)
		begin
			blink_reg <= 1'b0;
			flicker_reg <= 1'b0;
			fslot_reg <= '0;
		end
		else
		begin
			if (slot_end)
			begin
				blink_reg <= ~blink_reg;
				fslot_reg <= (fslot_reg == flash_len - 4'h1) ? '0
					: fslot_reg + 4'h1;
			end
			if (flk_end)
				flicker_reg <= ~flicker_reg;
		end
	end

	// ****************************************
	// Overtemperature latch
	// ****************************************
	logic temp_fault_reg;
	always_ff @(posedge clk_sys_i)
	begin
		if (!reset_n_i)
			temp_fault_reg <= 1'b0;
		else if (temp_trip_i)
			temp_fault_reg <= 1'b1;
		else if (fault_reset_i)
			temp_fault_reg <= 1'b0;
	end

	// ****************************************
	// Power indicator
	// ****************************************
	logic [2:0] err_cls;
	logic any_err;
	// Lowest class wins when several are active
	assign err_cls = err_general_i ? sli_pkg::CLS_GENERAL
		: err_voltage_i ? sli_pkg::CLS_VOLTAGE
		: temp_fault_reg ? sli_pkg::CLS_TEMP
		: err_overcur_i ? sli_pkg::CLS_OVERCUR
		: err_ctrl_i ? sli_pkg::CLS_CTRL
		: err_wdog_i ? sli_pkg::CLS_WDOG : 3'h0;
	assign any_err = (err_cls != 3'h0);

	logic [4:0] cslot_reg;
	logic [2:0] cls_reg;
	logic [4:0] count_len;
	logic count_on;
	// Class latched per frame so a switch to another class never cuts a count short
	assign count_len = {1'b0, cls_reg, 1'b0} + sli_pkg::COUNT_GAP_SLOTS;
	assign count_on = !cslot_reg[0] && (cslot_reg[4:1] < {1'b0, cls_reg});

	always_ff @(posedge clk_sys_i)
	begin
		if (!reset_n_i)
		begin
			cslot_reg <= '0;
			cls_reg <= '0;
		end
		else if (!any_err)
		begin
			cslot_reg <= '0;
			cls_reg <= '0;
		end
		else if (cls_reg == 3'h0)
			cls_reg <= err_cls;
		else if (slot_end)
		begin
			if (cslot_reg >= count_len - 5'h01)
			begin
				cslot_reg <= '0;
				cls_reg <= err_cls;
			end
			else
				cslot_reg <= cslot_reg + 5'h01;
		end
	end

	// ****************************************
	// Fieldbus indicators
	// ****************************************
	logic run_w;
	logic fault_w;
	always_comb
	begin
		run_w = 1'b0;
		if (bootloader_i)
			run_w = flicker_reg;
		else
			unique case (slave_state_i)
				sli_pkg::SLI_ST_BOOT: run_w = flicker_reg;
				sli_pkg::SLI_ST_INIT: run_w = 1'b0;
				sli_pkg::SLI_ST_PREOP: run_w = blink_reg;
				sli_pkg::SLI_ST_SAFEOP: run_w = single_w;
				sli_pkg::SLI_ST_OP: run_w = 1'b1;
				default: run_w = 1'b0;
			endcase
	end

	// Most severe condition shown first
	assign fault_w = fb_ctrl_fail_i ? 1'b1
		: fb_boot_err_i ? flicker_reg
		: fb_wdog_err_i ? double_w
		: fb_app_err_i ? triple_w
		: fb_local_err_i ? single_w
		: fb_cfg_err_i ? blink_reg : 1'b0;

	// ****************************************
	// Output registers
	// ****************************************
	always_ff @(posedge clk_sys_i)
	begin
		if (!reset_n_i)
		begin
			power_stage_en_o <= 1'b0;
			temp_fault_o <= 1'b0;
			power_green_o <= 1'b0;
			power_red_o <= 1'b0;
			link_indicator_o <= 1'b0;
			run_indicator_o <= 1'b0;
			fault_indicator_o <= 1'b0;
		end
		else
		begin
			power_stage_en_o <= !temp_fault_reg && !temp_trip_i;
			temp_fault_o <= temp_fault_reg || temp_trip_i;
			power_green_o <= !any_err && (beat_reg < 16'(PULSE_TICKS));
			power_red_o <= any_err && (cls_reg != 3'h0) && count_on;
			link_indicator_o <= link_up_i
				&& !(link_act_i && flicker_reg);
			run_indicator_o <= run_w;
			fault_indicator_o <= fault_w;
		end
	end
endmodule : sli_status_led

//--- verif/sli_status_led_sva.sv
// ****
// Port checks
// ****
module sli_status_led_chk (
	input wire logic clk_sys_i, // Clock
	input wire logic reset_n_i, // Reset
	input wire logic temp_trip_i, // Trip
	input wire logic fault_reset_i, // Ack
	input wire sli_pkg::sli_slave_t slave_state_i, // State
	input wire logic bootloader_i, // Loader
	input wire logic fb_ctrl_fail_i, // Dead
	input wire logic link_up_i, // Cable
	input wire logic power_stage_en_o, // Stage
	input wire logic temp_fault_o, // Flag
	input wire logic power_green_o, // Green
	input wire logic power_red_o, // Red
	input wire logic link_indicator_o, // Link
	input wire logic run_indicator_o, // Run
	input wire logic fault_indicator_o // Fault
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk_sys_i);
	endclocking
	default disable iff (!reset_n_i);
	trip_off_a: assert property (
		temp_trip_i |=> temp_fault_o && !power_stage_en_o) else $error("trip");
	fault_hold_a: assert property (
		temp_fault_o && temp_trip_i |=> temp_fault_o) else $error("hold");
	fault_clear_a: assert property ($fell(temp_fault_o) |->
		$past(fault_reset_i, 2) && !$past(temp_trip_i, 2)) else $error("clr");
	lamp_excl_a: assert property (
		!(power_green_o && power_red_o)) else $error("both");
	init_dark_a: assert property ((slave_state_i == sli_pkg::SLI_ST_INIT
		&& !bootloader_i) [*3] |-> !run_indicator_o) else $error("init");
	op_lit_a: assert property ((slave_state_i == sli_pkg::SLI_ST_OP
		&& !bootloader_i) [*3] |-> run_indicator_o) else $error("op");
	ctrl_lit_a: assert property (
		fb_ctrl_fail_i [*3] |-> fault_indicator_o) else $error("ctrl");
	link_dark_a: assert property (
		!link_up_i [*3] |-> !link_indicator_o) else $error("link");
endmodule : sli_status_led_chk
bind sli_status_led sli_status_led_chk sli_status_led_chk_i (.*);

//--- verif/sli_led_watch.sv
// ****
// Operator eye on one lamp
// ****
module sli_led_watch (
	input wire logic clk_i, // Clock
	input wire logic clear_i, // Restart
	input wire logic led_i, // Lamp
	output int rises_o, // Turn-ons
	output int lit_o // Lit cycles
);
	timeunit 1ns;
	timeprecision 1ns;
	logic prev;
	// An eye only sees turn-ons and brightness, so patterns are counted
	always @(posedge clk_i)
	begin
		rises_o <= clear_i ? 0 : rises_o + int'(led_i && !prev);
		lit_o <= clear_i ? 0 : lit_o + int'(led_i);
		prev <= led_i;
	end
endmodule : sli_led_watch

//--- verif/tb_sli_status_led.sv
module tb_sli_status_led;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic trip = 1'b0, fres = 1'b0, up = 1'b0, act = 1'b0, boot = 1'b0;
	logic clr = 1'b1;
	logic [4:0] err = 5'h00;
	logic [5:0] fb = 6'h00;
	sli_pkg::sli_slave_t st = sli_pkg::SLI_ST_INIT;
	wire logic [6:0] led;
	logic [2:0] sel = 3'h0;
	int rises, lit, failures = 0, total_checks = 0, cyc = 0;
	sli_status_led #(.TICK_CYC(1), .BLINK_TICKS(4), .FLICKER_TICKS(2),
		.BEAT_TICKS(40), .PULSE_TICKS(4)) sli_status_led_i (
		.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .temp_trip_i(trip),
		.fault_reset_i(fres), .err_general_i(err[0]), .err_voltage_i(err[1]),
		.err_overcur_i(err[2]), .err_ctrl_i(err[3]), .err_wdog_i(err[4]),
		.link_up_i(up), .link_act_i(act), .slave_state_i(st),
		.bootloader_i(boot), .fb_cfg_err_i(fb[0]), .fb_local_err_i(fb[1]),
		.fb_wdog_err_i(fb[2]), .fb_app_err_i(fb[3]), .fb_boot_err_i(fb[4]),
		.fb_ctrl_fail_i(fb[5]), .power_stage_en_o(led[0]),
		.temp_fault_o(led[1]), .power_green_o(led[2]), .power_red_o(led[3]),
		.link_indicator_o(led[4]), .run_indicator_o(led[5]),
		.fault_indicator_o(led[6]));
	sli_led_watch sli_led_watch_i (.clk_i(clk_sys_i), .clear_i(clr),
		.led_i(led[sel]), .rises_o(rises), .lit_o(lit));
	always #50 clk_sys_i = ~clk_sys_i;
	always @(posedge clk_sys_i)
	begin
		cyc <= cyc + 1;
		if (cyc > 90000)
		begin
			failures++;
			conclude();
		end
	end
	task check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			failures++;
			$display("wrong value at %0t: %0d not %0d", $time, seen, exp);
		end
	endtask : check
	task step(input int n);
		repeat (n) @(posedge clk_sys_i);
		#1;
	endtask : step
	// Settle past any old frame, then count whole periods only
	task watch(input logic [2:0] s, input int win, input int er, input int el);
		sel = s;
		step(80);
		clr = 1'b0;
		step(win);
		check(rises, er);
		check(lit, el);
		clr = 1'b1;
	endtask : watch
	task automatic t_class;
		int cls[5] = '{1, 2, 4, 5, 6};
		for (int i = 0; i < 5; i++)
		begin
			err = 5'h01 << i;
			watch(3, cls[i] * 8 + 16, cls[i], cls[i] * 4);
		end
		err = 5'h00;
		watch(3, 40, 0, 0);
		watch(2, 40, 1, 4);
	endtask : t_class
	task t_temp;
		trip = 1'b1;
		fres = 1'b1;
		step(3);
		check(led[1:0], 2'h2);
		watch(3, 40, 3, 12);
		trip = 1'b0;
		fres = 1'b0;
		step(3);
		check(led[1:0], 2'h2);
		fres = 1'b1;
		step(3);
		check(led[1:0], 2'h1);
		fres = 1'b0;
	endtask : t_temp
	task automatic t_run;
		int er[5] = '{22, 0, 11, 2, 0};
		int el[5] = '{44, 0, 44, 8, 88};
		for (int i = 0; i < 5; i++)
		begin
			st = sli_pkg::sli_slave_t'(i);
			watch(5, 88, er[i], el[i]);
		end
		boot = 1'b1;
		watch(5, 88, 22, 44);
		boot = 1'b0;
	endtask : t_run
	task automatic t_fault;
		int er[6] = '{11, 2, 4, 6, 22, 0};
		int el[6] = '{44, 8, 16, 24, 44, 88};
		for (int i = 0; i < 6; i++)
		begin
			fb = 6'h01 << i;
			watch(6, 88, er[i], el[i]);
		end
		fb = 6'h00;
		watch(6, 88, 0, 0);
	endtask : t_fault
	task t_link;
		up = 1'b1;
		watch(4, 88, 0, 88);
		act = 1'b1;
		watch(4, 88, 22, 44);
		up = 1'b0;
		act = 1'b0;
		watch(4, 88, 0, 0);
	endtask : t_link
	task conclude;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : conclude
	initial
	begin
		step(4);
		reset_n_i = 1'b1;
		t_class();
		t_temp();
		t_run();
		t_fault();
		t_link();
		conclude();
	end
endmodule : tb_sli_status_led
